// file: src/rms_pkg.sv
// constants and types shared by the regulator mode selector
package rms_pkg;

    // clock and timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int SWCLK_TIMEOUT_NS = 1000;
    // a least time: round up to whole cycles
    localparam int SWCLK_TIMEOUT_CYCLES =
        (SWCLK_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] ADDR_POWER_CONTROL_FIVE = 8'h00;
    localparam logic [7:0] ADDR_POWER_STATUS_TWO = 8'h04;
    localparam logic [7:0] ADDR_RADIO_SWITCHER_CONTROL_ZERO = 8'h08;
    localparam logic [7:0] ADDR_RADIO_SWITCHER_DRIVE_CONTROL = 8'h0c;
    localparam logic [7:0] ADDR_RADIO_INRUSH_CONTROL = 8'h10;

    // field positions
    localparam int BIT_MCU_SWITCHER_REQUEST = 0;
    localparam int BIT_SWITCHER_IN_USE_FLAG = 0;
    localparam int BIT_LDO_ON = 1;
    localparam int BIT_RADIO_REQUEST = 2;
    localparam int BIT_HOLD_ACTIVE = 3;
    localparam int BIT_SWITCHER_CLOCK_DETECT_ENABLE = 0;
    localparam int BIT_SWITCHER_CLOCK_FAIL = 1;

    // reset values
    localparam logic [3:0] RESET_CURRENT_LIMIT = 4'h0;
    localparam logic [1:0] RESET_INRUSH = 2'h0;

    ////////////////////////////////////////////////////////////////////////
    // radio operating modes
    localparam logic [2:0] RADIO_SLEEP = 3'h0;
    localparam logic [2:0] RADIO_CALIBRATE = 3'h1;
    localparam logic [2:0] RADIO_STANDBY = 3'h2;
    localparam logic [2:0] RADIO_STANDBY_XTAL = 3'h3;
    localparam logic [2:0] RADIO_ACTIVE = 3'h4;
    localparam logic [2:0] RADIO_DEEP_SLEEP = 3'h5;

    // system operating modes (shutdown ends in a reset, so it has no code)
    localparam logic [2:0] SYS_RUN = 3'h0;
    localparam logic [2:0] SYS_SLEEP = 3'h1;
    localparam logic [2:0] SYS_LPRUN = 3'h2;
    localparam logic [2:0] SYS_LPSLEEP = 3'h3;
    localparam logic [2:0] SYS_STOP0 = 3'h4;
    localparam logic [2:0] SYS_STOP1 = 3'h5;
    localparam logic [2:0] SYS_STOP2 = 3'h6;
    localparam logic [2:0] SYS_STANDBY = 3'h7;

    typedef enum logic [1:0] {
        RMS_ST_LDO = 2'b00,
        RMS_ST_SWITCHER = 2'b01,
        RMS_ST_OFF = 2'b11
    } rms_supply_state_type;

endpackage : rms_pkg

// file: src/rms_clock_monitor.sv
// converter clock loss detector: flags a missing clock tick
`timescale 1ns/100ps
module rms_clock_monitor #(
    parameter int TIMEOUT_CYCLES = rms_pkg::SWCLK_TIMEOUT_CYCLES,
    parameter int CNT_W = 8
) (
    input wire logic clk,           // system clock
    input wire logic rst,           // async reset, active high
    input wire logic enable,        // detector armed
    input wire logic switcher_tick, // one pulse per converter clock period
    output logic clock_fail         // one-cycle pulse on clock loss
);

    localparam logic [CNT_W-1:0] LAST = CNT_W'(TIMEOUT_CYCLES - 1);

    logic [CNT_W-1:0] quiet_count;

    // counts cycles since the last tick; disarmed means no count at all
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            quiet_count <= '0;
        end else if (!enable || switcher_tick || quiet_count == LAST) begin
            quiet_count <= '0;
        end else begin
            quiet_count <= quiet_count + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clock_fail <= 1'b0;
        end else begin
            clock_fail <= enable && !switcher_tick && quiet_count == LAST;
        end
    end

endmodule : rms_clock_monitor

// file: src/rms_selector.sv
// regulator mode selector: picks linear regulator or switching converter
`timescale 1ns/100ps
module rms_selector #(
    parameter int LIMIT_W = 4,
    parameter int INRUSH_W = 2,
    parameter int TIMEOUT_CYCLES = rms_pkg::SWCLK_TIMEOUT_CYCLES
) (
    input wire logic clk,                        // system clock, 20 MHz
    input wire logic rst,                        // power-on reset, async
    input wire logic external_reset_pin_n,       // pin reset, sync, low
    input wire logic psel,                       // apb select
    input wire logic penable,                    // apb enable
    input wire logic pwrite,                     // apb direction
    input wire logic [7:0] paddr,                // apb byte address
    input wire logic [31:0] pwdata,              // apb write data
    output logic [31:0] prdata,                  // apb read data
    output logic pready,                         // apb ready
    output logic pslverr,                        // apb error, unmapped
    input wire logic [2:0] system_mode,          // mcu operating mode
    input wire logic [2:0] radio_mode,           // radio operating mode
    input wire logic radio_regulator_select_cmd, // radio command pulse
    input wire logic radio_regulator_select_value, // 1 converter, 0 ldo
    input wire logic switcher_tick,              // converter clock pulse
    output logic ldo_enable,                     // linear regulator on
    output logic switcher_enable,                // switching converter on
    output logic [LIMIT_W-1:0] switcher_current_limit, // max load select
    output logic [INRUSH_W-1:0] inrush_setting   // inrush control
);

    logic mcu_switcher_request;
    logic radio_switcher_request;
    logic switcher_clock_detect_enable;
    logic switcher_clock_fail;
    logic [LIMIT_W-1:0] radio_switcher_drive_control;
    logic [INRUSH_W-1:0] radio_inrush_control;
    rms_pkg::rms_supply_state_type state;
    rms_pkg::rms_supply_state_type next_state;
    logic deep_low_power;
    logic deep_low_power_prev;
    logic radio_hold;
    logic radio_busy;
    logic deep_off;
    logic low_power_exit;
    logic fail_pulse;
    logic pin_reset;
    logic wr_access;
    logic rd_setup;
    logic [31:0] read_word;
    logic addr_hit;

    ////////////////////////////////////////////////////////////////////////
    // mode decode

    assign pin_reset = !external_reset_pin_n;
    assign radio_busy = radio_mode == rms_pkg::RADIO_ACTIVE;
    assign radio_hold = radio_busy
        || radio_mode == rms_pkg::RADIO_STANDBY_XTAL;
    assign deep_low_power = system_mode == rms_pkg::SYS_STOP1
        || system_mode == rms_pkg::SYS_STOP2
        || system_mode == rms_pkg::SYS_STANDBY;
    // radio activity keeps the supply alive even in deep modes
    assign deep_off = deep_low_power && !radio_busy;
    assign low_power_exit = deep_low_power_prev && !deep_low_power;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            deep_low_power_prev <= 1'b0;
        end else begin
            deep_low_power_prev <= deep_low_power;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // converter clock loss detection, armed only while converter runs

    rms_clock_monitor #(
        .TIMEOUT_CYCLES(TIMEOUT_CYCLES),
        .CNT_W(8)
    ) u_clock_monitor (
        .clk(clk),
        .rst(rst),
        .enable(switcher_clock_detect_enable
            && state == rms_pkg::RMS_ST_SWITCHER),
        .switcher_tick(switcher_tick),
        .clock_fail(fail_pulse)
    );

    ////////////////////////////////////////////////////////////////////////
    // supply state machine

    always_comb begin
        next_state = state;
        unique case (state)
            rms_pkg::RMS_ST_LDO, rms_pkg::RMS_ST_SWITCHER: begin
                // a deep mode turns both off, so a loss there needs no ldo
                if (deep_off) begin
                    next_state = rms_pkg::RMS_ST_OFF;
                end else if (fail_pulse) begin
                    next_state = rms_pkg::RMS_ST_LDO;
                end else if (radio_busy && radio_regulator_select_cmd) begin
                    // radio overrides software while it is active
                    next_state = (radio_regulator_select_value
                        && !switcher_clock_fail)
                        ? rms_pkg::RMS_ST_SWITCHER
                        : rms_pkg::RMS_ST_LDO;
                end else if (!radio_hold) begin
                    next_state = ((mcu_switcher_request
                        || radio_switcher_request)
                        && !switcher_clock_fail)
                        ? rms_pkg::RMS_ST_SWITCHER
                        : rms_pkg::RMS_ST_LDO;
                end
            end
            rms_pkg::RMS_ST_OFF: begin
                if (!deep_off) begin
                    next_state = (mcu_switcher_request && !switcher_clock_fail)
                        ? rms_pkg::RMS_ST_SWITCHER
                        : rms_pkg::RMS_ST_LDO;
                end
            end
            default: begin
                next_state = rms_pkg::RMS_ST_LDO;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= rms_pkg::RMS_ST_LDO;
        end else if (pin_reset) begin
            state <= rms_pkg::RMS_ST_LDO;
        end else begin
            state <= next_state;
        end
    end

    // outputs registered from the same next value so they track the state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ldo_enable <= 1'b1;
            switcher_enable <= 1'b0;
        end else if (pin_reset) begin
            ldo_enable <= 1'b1;
            switcher_enable <= 1'b0;
        end else begin
            ldo_enable <= next_state == rms_pkg::RMS_ST_LDO;
            switcher_enable <= next_state == rms_pkg::RMS_ST_SWITCHER;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request sources

    assign wr_access = psel && penable && pready && pwrite;
    assign rd_setup = psel && !penable;

    // only a reset clears it; low-power modes leave it alone
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mcu_switcher_request <= 1'b0;
        end else if (pin_reset) begin
            mcu_switcher_request <= 1'b0;
        end else if (wr_access && paddr == rms_pkg::ADDR_POWER_CONTROL_FIVE) begin
            mcu_switcher_request <=
                pwdata[rms_pkg::BIT_MCU_SWITCHER_REQUEST];
        end
    end

    // a command taken under hold waits here until the hold ends
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            radio_switcher_request <= 1'b0;
        end else if (pin_reset || low_power_exit || deep_off) begin
            radio_switcher_request <= 1'b0;
        end else if (radio_regulator_select_cmd) begin
            radio_switcher_request <= radio_regulator_select_value;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // radio-side converter controls

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            switcher_clock_detect_enable <= 1'b0;
        end else if (pin_reset) begin
            switcher_clock_detect_enable <= 1'b0;
        end else if (wr_access
            && paddr == rms_pkg::ADDR_RADIO_SWITCHER_CONTROL_ZERO) begin
            switcher_clock_detect_enable <=
                pwdata[rms_pkg::BIT_SWITCHER_CLOCK_DETECT_ENABLE];
        end
    end

    // sticky; blocks the converter until cleared; a new failure beats clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            switcher_clock_fail <= 1'b0;
        end else if (pin_reset) begin
            switcher_clock_fail <= 1'b0;
        end else if (fail_pulse) begin
            switcher_clock_fail <= 1'b1;
        end else if (wr_access
            && paddr == rms_pkg::ADDR_RADIO_SWITCHER_CONTROL_ZERO
            && pwdata[rms_pkg::BIT_SWITCHER_CLOCK_FAIL]) begin
            switcher_clock_fail <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            radio_switcher_drive_control <=
                LIMIT_W'(rms_pkg::RESET_CURRENT_LIMIT);
        end else if (wr_access
            && paddr == rms_pkg::ADDR_RADIO_SWITCHER_DRIVE_CONTROL) begin
            radio_switcher_drive_control <= pwdata[LIMIT_W-1:0];
        end
    end

    // only radio deep-sleep loses the setting
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            radio_inrush_control <= INRUSH_W'(rms_pkg::RESET_INRUSH);
        end else if (radio_mode == rms_pkg::RADIO_DEEP_SLEEP) begin
            radio_inrush_control <= INRUSH_W'(rms_pkg::RESET_INRUSH);
        end else if (wr_access
            && paddr == rms_pkg::ADDR_RADIO_INRUSH_CONTROL) begin
            radio_inrush_control <= pwdata[INRUSH_W-1:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            switcher_current_limit <= LIMIT_W'(rms_pkg::RESET_CURRENT_LIMIT);
            inrush_setting <= INRUSH_W'(rms_pkg::RESET_INRUSH);
        end else begin
            switcher_current_limit <= radio_switcher_drive_control;
            inrush_setting <= radio_inrush_control;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb read decode

    always_comb begin
        read_word = 32'h0000_0000;
        addr_hit = 1'b1;
        unique case (paddr)
            rms_pkg::ADDR_POWER_CONTROL_FIVE: begin
                read_word[rms_pkg::BIT_MCU_SWITCHER_REQUEST] =
                    mcu_switcher_request;
            end
            rms_pkg::ADDR_POWER_STATUS_TWO: begin
                read_word[rms_pkg::BIT_SWITCHER_IN_USE_FLAG] =
                    state == rms_pkg::RMS_ST_SWITCHER;
                read_word[rms_pkg::BIT_LDO_ON] =
                    state == rms_pkg::RMS_ST_LDO;
                read_word[rms_pkg::BIT_RADIO_REQUEST] = radio_switcher_request;
                read_word[rms_pkg::BIT_HOLD_ACTIVE] = radio_hold;
            end
            rms_pkg::ADDR_RADIO_SWITCHER_CONTROL_ZERO: begin
                read_word[rms_pkg::BIT_SWITCHER_CLOCK_DETECT_ENABLE] =
                    switcher_clock_detect_enable;
                read_word[rms_pkg::BIT_SWITCHER_CLOCK_FAIL] =
                    switcher_clock_fail;
            end
            rms_pkg::ADDR_RADIO_SWITCHER_DRIVE_CONTROL: begin
                read_word[LIMIT_W-1:0] = radio_switcher_drive_control;
            end
            rms_pkg::ADDR_RADIO_INRUSH_CONTROL: begin
                read_word[INRUSH_W-1:0] = radio_inrush_control;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // one wait-free access phase: ready rises the cycle after setup
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= rd_setup;
            pslverr <= rd_setup && !addr_hit;
            if (rd_setup && !pwrite) begin
                prdata <= read_word;
            end else if (!psel) begin
                prdata <= 32'h0000_0000;
            end
        end
    end

endmodule : rms_selector

// file: bench/rms_selector_assertions.sv
// checker for the regulator mode selector, bound to its top module
`timescale 1ns/100ps
module rms_selector_checker #(
    parameter int LIMIT_W = 4,
    parameter int INRUSH_W = 2,
    parameter int TIMEOUT_CYCLES = rms_pkg::SWCLK_TIMEOUT_CYCLES
) (
    input wire logic clk, // system clock
    input wire logic rst, // power-on reset
    input wire logic external_reset_pin_n, // pin reset, low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic [2:0] system_mode, // mcu mode
    input wire logic [2:0] radio_mode, // radio mode
    input wire logic radio_regulator_select_cmd, // radio command
    input wire logic radio_regulator_select_value, // command value
    input wire logic switcher_tick, // converter clock
    input wire logic ldo_enable, // linear on
    input wire logic switcher_enable, // converter on
    input wire logic [LIMIT_W-1:0] switcher_current_limit, // load limit
    input wire logic [INRUSH_W-1:0] inrush_setting // inrush
);
    logic arm_seen;
    logic [7:0] quiet;
    logic deep_sys;
    logic deep_off;
    assign deep_sys = system_mode inside {rms_pkg::SYS_STOP1,
        rms_pkg::SYS_STOP2, rms_pkg::SYS_STANDBY};
    assign deep_off = deep_sys && external_reset_pin_n &&
        radio_mode inside {rms_pkg::RADIO_SLEEP, rms_pkg::RADIO_STANDBY};
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    // shadow of the detector arm bit; the design's own copy is not a port
    always_ff @(posedge clk or posedge rst) begin
        if (rst) arm_seen <= 1'b0;
        else if (!external_reset_pin_n) arm_seen <= 1'b0;
        else if (psel && penable && pready && pwrite &&
                 paddr == rms_pkg::ADDR_RADIO_SWITCHER_CONTROL_ZERO)
            arm_seen <= pwdata[0];
    end
    // quiet converter cycles while armed
    always_ff @(posedge clk or posedge rst) begin
        if (rst) quiet <= 8'h00;
        else if (switcher_tick || !switcher_enable || !arm_seen)
            quiet <= 8'h00;
        else if (quiet != 8'hff) quiet <= quiet + 8'h01;
    end
    ////////////////////////////////////////////////////////////////////////
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    sequence s_hold_ldo;
        radio_mode == rms_pkg::RADIO_STANDBY_XTAL && !deep_sys &&
            !switcher_enable;
    endsequence
    AST_EXCLUSIVE:
        assert property (!(ldo_enable && switcher_enable))
        else $error("both regulators enabled together");
    AST_PIN_RESET:
        assert property (!external_reset_pin_n |=>
            ldo_enable && !switcher_enable)
        else $error("pin reset did not select the linear regulator");
    AST_DEEP_OFF:
        assert property (deep_off [*2] |-> !ldo_enable && !switcher_enable)
        else $error("regulator left on in a deep mode");
    AST_HOLD_XTAL:
        assert property (s_hold_ldo [*2] |=> !switcher_enable)
        else $error("supply changed while radio held it");
    AST_RADIO_CMD:
        assert property (radio_mode == rms_pkg::RADIO_ACTIVE &&
            external_reset_pin_n && radio_regulator_select_cmd &&
            radio_regulator_select_value |=> switcher_enable)
        else $error("radio command did not select the converter");
    AST_INRUSH_DEEP:
        assert property ((radio_mode == rms_pkg::RADIO_DEEP_SLEEP) [*2]
            |=> inrush_setting == '0)
        else $error("inrush setting kept in radio deep sleep");
    AST_APB_ANSWER:
        assert property (s_setup |=> s_access ##0 pready)
        else $error("no ready in the access cycle");
    AST_APB_ONLY:
        assert property (pready |-> psel && penable &&
            $past(psel && !penable))
        else $error("ready outside an access cycle");
    AST_UNMAPPED:
        assert property (s_access ##0 (pready &&
            paddr > rms_pkg::ADDR_RADIO_INRUSH_CONTROL)
            |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_CLKFAIL:
        assert property (quiet > TIMEOUT_CYCLES + 3 |-> !switcher_enable)
        else $error("converter kept on after its clock stopped");
endmodule : rms_selector_checker
bind rms_selector rms_selector_checker #(.LIMIT_W(LIMIT_W),
    .INRUSH_W(INRUSH_W), .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) i_rms_selector_checker (.clk(clk), .rst(rst),
    .external_reset_pin_n(external_reset_pin_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .system_mode(system_mode), .radio_mode(radio_mode),
    .radio_regulator_select_cmd(radio_regulator_select_cmd),
    .radio_regulator_select_value(radio_regulator_select_value),
    .switcher_tick(switcher_tick), .ldo_enable(ldo_enable),
    .switcher_enable(switcher_enable),
    .switcher_current_limit(switcher_current_limit),
    .inrush_setting(inrush_setting));

// file: bench/rms_far_model.sv
// far-side model: converter clock and radio regulator commands
`timescale 1ns/100ps
module rms_far_model (
    input wire logic clk, // system clock
    input wire logic tick_on, // converter clock running
    input wire logic cmd_go, // bench asks for a radio command
    input wire logic cmd_val, // wanted supply, 1 converter
    output logic switcher_tick, // converter clock pulse
    output logic radio_regulator_select_cmd, // one-cycle command
    output logic radio_regulator_select_value // valid with the command
);
    logic [1:0] div = 2'h0;
    logic tick_q = 1'b0;
    logic cmd_q = 1'b0;
    logic val_q = 1'b0;
    always_ff @(posedge clk) begin
        div <= div + 2'h1;
        tick_q <= tick_on && div == 2'h0;
    end
    // value line toggles outside commands so nothing relies on it
    always_ff @(posedge clk) begin
        cmd_q <= cmd_go;
        val_q <= cmd_go ? cmd_val : ~val_q;
    end
    assign switcher_tick = tick_q;
    assign radio_regulator_select_cmd = cmd_q;
    assign radio_regulator_select_value = val_q;
endmodule : rms_far_model

// file: bench/tb_top.sv
// self-checking bench for the regulator mode selector
`timescale 1ns/100ps
module tb_top;
    localparam int TMO = 4;
    logic clk = 1'b0, rst = 1'b1, external_reset_pin_n = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, ldo_enable, switcher_enable, cmd, val, tick;
    logic [2:0] system_mode = rms_pkg::SYS_RUN;
    logic [2:0] radio_mode = rms_pkg::RADIO_SLEEP;
    logic tick_on = 1'b0, cmd_go = 1'b0, cmd_val = 1'b0;
    logic [3:0] limit;
    logic [1:0] inrush;
    logic [65:0] q[$];
    logic [65:0] e;
    int err_total = 0, n_tests = 0;
    rms_selector #(.TIMEOUT_CYCLES(TMO)) i_rms_selector (.clk(clk),
        .rst(rst), .external_reset_pin_n(external_reset_pin_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .system_mode(system_mode),
        .radio_mode(radio_mode), .radio_regulator_select_cmd(cmd),
        .radio_regulator_select_value(val), .switcher_tick(tick),
        .ldo_enable(ldo_enable), .switcher_enable(switcher_enable),
        .switcher_current_limit(limit), .inrush_setting(inrush));
    rms_far_model i_rms_far_model (.clk(clk), .tick_on(tick_on),
        .cmd_go(cmd_go), .cmd_val(cmd_val), .switcher_tick(tick),
        .radio_regulator_select_cmd(cmd),
        .radio_regulator_select_value(val));
    initial begin
        forever #25 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    // one apb transfer; waits for ready, however long it takes
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    // expected {pslverr, prdata} under a mask, checked by the monitor
    task automatic rd(input logic [7:0] a, input logic [32:0] x,
                      input logic [32:0] m);
        q.push_back({m, x});
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic regs(input logic [1:0] x);
        chk({31'h0, ldo_enable, switcher_enable}, {31'h0, x});
    endtask : regs
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e = q.pop_front();
            chk({pslverr, prdata} & e[65:33], e[32:0]);
        end
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (3000) @(posedge clk);
        err_total++;
        report_and_stop();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h0568aa37));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        regs(2'b10);
        for (int i = 0; i < 6; i++) begin
            rd(8'(i * 4), (i == 5) ? 33'h100000000 : (i == 1) ? 33'h2 : 33'h0,
               (i == 1) ? 33'h3 : '1);
        end
        $display("done: reset values");
        tick_on <= 1'b1;
        wr(8'h08, 32'h1);
        wr(8'h00, 32'h1);
        cyc(2);
        rd(8'h04, 33'h1, 33'h3);
        r = $urandom;
        wr(8'h0c, r);
        wr(8'h10, r);
        cyc(2);
        rd(8'h0c, {29'h0, r[3:0]}, '1);
        rd(8'h10, {31'h0, r[1:0]}, '1);
        chk({29'h0, limit}, {29'h0, r[3:0]});
        chk({31'h0, inrush}, {31'h0, r[1:0]});
        $display("done: mcu request and radio settings");
        radio_mode <= rms_pkg::RADIO_STANDBY_XTAL;
        cyc(2);
        wr(8'h00, 32'h0);
        cyc(3);
        regs(2'b01);
        radio_mode <= rms_pkg::RADIO_STANDBY;
        cyc(3);
        regs(2'b10);
        radio_mode <= rms_pkg::RADIO_STANDBY_XTAL;
        wr(8'h00, 32'h1);
        cyc(3);
        regs(2'b10);
        wr(8'h00, 32'h0);
        $display("done: radio hold");
        radio_mode <= rms_pkg::RADIO_ACTIVE;
        cyc(2);
        cmd_go <= 1'b1;
        cmd_val <= 1'b1;
        @(posedge clk);
        cmd_go <= 1'b0;
        cyc(3);
        regs(2'b01);
        radio_mode <= rms_pkg::RADIO_STANDBY;
        cyc(3);
        regs(2'b01);
        $display("done: radio command");
        wr(8'h00, 32'h1);
        radio_mode <= rms_pkg::RADIO_SLEEP;
        for (int m = 5; m < 8; m++) begin
            system_mode <= 3'(m);
            cyc(3);
            regs(2'b00);
            system_mode <= rms_pkg::SYS_RUN;
            cyc(3);
            regs(2'b01);
        end
        rd(8'h00, 33'h1, '1);
        radio_mode <= rms_pkg::RADIO_DEEP_SLEEP;
        cyc(4);
        chk({31'h0, inrush}, 33'h0);
        radio_mode <= rms_pkg::RADIO_SLEEP;
        $display("done: low-power modes");
        tick_on <= 1'b0;
        cyc(TMO + 8);
        regs(2'b10);
        rd(8'h08, 33'h3, '1);
        tick_on <= 1'b1;
        wr(8'h08, 32'h3);
        cyc(2);
        regs(2'b01);
        rd(8'h08, 33'h1, '1);
        $display("done: converter clock loss");
        external_reset_pin_n <= 1'b0;
        cyc(2);
        external_reset_pin_n <= 1'b1;
        cyc(1);
        regs(2'b10);
        rd(8'h00, 33'h0, '1);
        rd(8'h08, 33'h0, '1);
        $display("done: pin reset");
        report_and_stop();
    end
endmodule : tb_top
